//--- hsl_loader.sv
// Hub serial identifier loader with port power control and APB registers
`timescale 1ns/1ps

module hsl_loader
  import hsl_pkg::*;
(
  // Clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  // APB slave
  input  wire logic                 i_psel,
  input  wire logic                 i_penable,
  input  wire logic                 i_pwrite,
  input  wire logic [7:0]           i_paddr,
  input  wire logic [31:0]          i_pwdata,
  output logic      [31:0]          o_prdata,
  output logic                      o_pready,
  output logic                      o_pslverr,
  // Straps and fault pins
  input  wire logic                 i_ext_memory_enable_n,
  input  wire logic                 i_bus_power_select,
  input  wire logic [NUM_PORTS-1:0] i_overcurrent_n,
  // Serial memory pins
  output logic                      o_serial_memory_clock,
  output logic                      o_serial_memory_clock_oe,
  input  wire logic                 i_serial_memory_data,
  output logic                      o_serial_memory_data,
  output logic                      o_serial_memory_data_oe,
  output logic                      o_pulldown_en,
  // Power management
  output logic [NUM_PORTS-1:0]      o_port_power_on,
  output logic [1:0]                o_power_mode,
  output logic                      o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [1:0]           ext_sync_r;
  logic [1:0]           bus_sync_r;
  logic [1:0]           data_sync_r;
  logic [NUM_PORTS-1:0] oc_meta_r;
  logic [NUM_PORTS-1:0] oc_sync_r;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ext_sync_r  <= 2'h3;
      bus_sync_r  <= 2'h0;
      data_sync_r <= 2'h0;
      oc_meta_r   <= {NUM_PORTS{1'b1}};
      oc_sync_r   <= {NUM_PORTS{1'b1}};
    end else begin
      ext_sync_r  <= {ext_sync_r[0], i_ext_memory_enable_n};
      bus_sync_r  <= {bus_sync_r[0], i_bus_power_select};
      data_sync_r <= {data_sync_r[0], i_serial_memory_data};
      oc_meta_r   <= i_overcurrent_n;
      oc_sync_r   <= oc_meta_r;
    end
  end

  // Strap resets to off: no pull-down and no read before the synced level
  wire ext_en     = ~ext_sync_r[1];
  wire data_in    = data_sync_r[1];
  wire [NUM_PORTS-1:0] fault_now = ~oc_sync_r;

  ////////////////////////////////////////////////////////////////////////////
  // Serial read engine
  hsl_state_e  state_r;
  hsl_state_e  state_nxt;
  logic [3:0]  div_cnt_r;
  logic        sclk_r;
  logic        sclk_oe_r;
  logic [7:0]  cmd_sr_r;
  logic        data_oe_r;
  logic [5:0]  bit_cnt_r;
  logic [47:0] rx_sr_r;
  logic        strap_ext_r;
  hsl_ident_s  ident_r;
  logic        load_done_pulse;

  wire active   = (state_r == ST_SEND) || (state_r == ST_RECV);
  wire div_last = (div_cnt_r == SER_HALF_LAST);
  wire sclk_fall = active & div_last & sclk_r;
  wire send_end  = (state_r == ST_SEND) & sclk_fall & (bit_cnt_r == CMD_BITS_LAST);
  wire recv_end  = (state_r == ST_RECV) & sclk_fall & (bit_cnt_r == RX_BITS_LAST);
  wire wait_end  = (state_r == ST_STRAP_WAIT) & (div_cnt_r == STRAP_WAIT_LAST);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_STRAP_WAIT: begin
        if (wait_end) begin
          state_nxt = ext_en ? ST_SEND : ST_SKIP;
        end
      end
      ST_SEND: begin
        if (send_end) begin
          state_nxt = ST_RECV;
        end
      end
      ST_RECV: begin
        if (recv_end) begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE:  state_nxt = ST_DONE;
      ST_SKIP:  state_nxt = ST_SKIP;
      default:  state_nxt = ST_STRAP_WAIT;
    endcase
  end

  assign load_done_pulse = recv_end;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r <= ST_STRAP_WAIT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Divider doubles as the strap settle counter
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      div_cnt_r <= 4'h0;
    end else if (wait_end || (active && div_last)) begin
      div_cnt_r <= 4'h0;
    end else if (active || state_r == ST_STRAP_WAIT) begin
      div_cnt_r <= div_cnt_r + 4'h1;
    end
  end

  // Device-made serial clock, floats once done
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sclk_r    <= 1'b0;
      sclk_oe_r <= 1'b0;
    end else begin
      if (recv_end) begin
        sclk_r <= 1'b0;
      end else if (active && div_last) begin
        sclk_r <= ~sclk_r;
      end
      // Enables follow the next state so they move with the state change
      sclk_oe_r <= (state_nxt == ST_SEND) || (state_nxt == ST_RECV);
    end
  end

  // Command shifter, changes while clock is low
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cmd_sr_r  <= CMD_READ_WORD0;
      data_oe_r <= 1'b0;
    end else begin
      if (state_r == ST_SEND && sclk_fall) begin
        cmd_sr_r <= {cmd_sr_r[6:0], 1'b0};
      end
      data_oe_r <= (state_nxt == ST_SEND);
    end
  end

  // Bit counter and receive shifter; first read bit is the dummy
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      bit_cnt_r <= 6'h00;
      rx_sr_r   <= 48'h0;
    end else if (send_end) begin
      bit_cnt_r <= 6'h00;
    end else if (active && sclk_fall) begin
      bit_cnt_r <= bit_cnt_r + 6'h01;
      if (state_r == ST_RECV && bit_cnt_r != 6'h00) begin
        rx_sr_r <= {rx_sr_r[46:0], data_in};
      end
    end
  end

  // Latch words once the third arrives
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ident_r     <= '{word0: 16'h0000, vendor_identifier: VENDOR_ID_DEFAULT,
                       product_identifier: PRODUCT_ID_DEFAULT};
      strap_ext_r <= 1'b0;
    end else begin
      if (wait_end) begin
        strap_ext_r <= ext_en;
      end
      if (recv_end) begin
        ident_r <= {rx_sr_r[46:0], data_in};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pull-downs and power mode
  logic       pulldown_r;
  logic       ganged_r;
  logic [1:0] mode_r;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pulldown_r <= 1'b0;
      ganged_r   <= 1'b0;
      mode_r     <= 2'h0;
    end else begin
      pulldown_r <= ext_en;
      // Without a memory the data pin carries the ganged level
      if (state_r == ST_DONE) begin
        ganged_r <= ident_r.word0[GANGED_BIT];
      end else if (state_r == ST_SKIP) begin
        ganged_r <= data_in;
      end
      mode_r <= {bus_sync_r[1], ganged_r};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port power and interrupts
  logic [NUM_PORTS-1:0] port_en_r;
  logic [NUM_PORTS-1:0] port_on_r;
  logic [4:0]           int_stat_r;
  logic [4:0]           int_en_r;
  logic                 irq_r;
  logic [4:0]           int_set;
  logic [4:0]           int_clr;
  wire  [NUM_PORTS-1:0] fault_lat = int_stat_r[INT_FAULT_LSB +: NUM_PORTS];
  wire  ready_ports = (state_r == ST_DONE) || (state_r == ST_SKIP);

  // APB decode
  // Ready is a flop, so each access gets one wait state
  wire apb_access = i_psel & i_penable & ~o_pready;
  wire apb_commit = i_psel & i_penable & o_pready;
  wire apb_wr     = apb_commit & i_pwrite;

  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] r);
    addr_hit = (a == r);
  endfunction : addr_hit

  wire hit_ctrl   = addr_hit(i_paddr, ADDR_CTRL);
  wire hit_status = addr_hit(i_paddr, ADDR_STATUS);
  wire hit_ident  = addr_hit(i_paddr, ADDR_IDENT);
  wire hit_word0  = addr_hit(i_paddr, ADDR_WORD0);
  wire hit_istat  = addr_hit(i_paddr, ADDR_INT_STATUS);
  wire hit_iclr   = addr_hit(i_paddr, ADDR_INT_CLEAR);
  wire hit_ien    = addr_hit(i_paddr, ADDR_INT_ENABLE);
  wire hit_any    = hit_ctrl | hit_status | hit_ident | hit_word0 |
                    hit_istat | hit_iclr | hit_ien;

  assign int_clr = (apb_wr && hit_iclr) ? i_pwdata[4:0] : 5'h00;

  // A latched fault holds its port off until software clears it
  genvar g;
  generate
    for (g = 0; g < NUM_PORTS; g++) begin : g_port
      // Ganged: any fault trips all; individual: only its own
      assign int_set[INT_FAULT_LSB + g] = ganged_r ? (|fault_now) : fault_now[g];
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          port_on_r[g] <= 1'b0;
        end else begin
          port_on_r[g] <= ready_ports & port_en_r[g] & ~fault_lat[g] &
                          ~int_set[INT_FAULT_LSB + g];
        end
      end
    end
  endgenerate

  assign int_set[INT_LOAD_DONE] = load_done_pulse;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      int_stat_r <= 5'h00;
      int_en_r   <= INT_EN_RESET;
      port_en_r  <= CTRL_RESET;
      irq_r      <= 1'b0;
    end else begin
      int_stat_r <= (int_stat_r & ~int_clr) | int_set;        // Set wins
      if (apb_wr && hit_ien) begin
        int_en_r <= i_pwdata[4:0];
      end
      if (apb_wr && hit_ctrl) begin
        port_en_r <= i_pwdata[3:0];
      end
      irq_r <= |(int_stat_r & int_en_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB read data and answer, one wait state
  logic [31:0] rd_mux;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;

  assign rd_mux =
      hit_ctrl   ? {28'h0, port_en_r} :
      hit_status ? {24'h0, mode_r, ganged_r, strap_ext_r, 1'b0, state_r} :
      hit_ident  ? {ident_r.vendor_identifier, ident_r.product_identifier} :
      hit_word0  ? {16'h0, ident_r.word0} :
      hit_istat  ? {27'h0, int_stat_r} :
      hit_ien    ? {27'h0, int_en_r} :
                   32'h0;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      prdata_r  <= 32'h0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= apb_access;
      pslverr_r <= apb_access & ~hit_any;
      prdata_r  <= (apb_access && !i_pwrite) ? rd_mux : 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign o_prdata                 = prdata_r;
  assign o_pready                 = pready_r;
  assign o_pslverr                = pslverr_r;
  assign o_serial_memory_clock    = sclk_r;
  assign o_serial_memory_clock_oe = sclk_oe_r;
  assign o_serial_memory_data     = cmd_sr_r[7];
  assign o_serial_memory_data_oe  = data_oe_r;
  assign o_pulldown_en            = pulldown_r;
  assign o_port_power_on          = port_on_r;
  assign o_power_mode             = mode_r;
  assign o_irq                    = irq_r;

endmodule : hsl_loader

//--- hsl_pkg.sv
// Constants, types and register map of the hub serial identifier loader
package hsl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and serial timing
  localparam int unsigned CLK_PERIOD_NS     = 5;
  localparam int unsigned SER_CLK_PERIOD_NS = 80;
  localparam int unsigned SER_HALF_CYC      = SER_CLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam logic [3:0]  SER_HALF_LAST     = 4'(SER_HALF_CYC - 1);
  localparam logic [3:0]  STRAP_WAIT_LAST   = 4'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Serial read sequence: start 1, opcode 10, address 00000
  localparam logic [7:0]  CMD_READ_WORD0    = 8'hc0;
  localparam logic [5:0]  CMD_BITS_LAST     = 6'h07;
  localparam logic [5:0]  RX_BITS_LAST      = 6'h30;
  localparam int unsigned WORD_W            = 16;
  localparam int unsigned NUM_WORDS         = 3;
  localparam int unsigned GANGED_BIT        = 14;
  localparam int unsigned NUM_PORTS         = 4;

  ////////////////////////////////////////////////////////////////////////////
  // APB register byte addresses
  localparam logic [7:0]  ADDR_CTRL         = 8'h00;
  localparam logic [7:0]  ADDR_STATUS       = 8'h04;
  localparam logic [7:0]  ADDR_IDENT        = 8'h08;
  localparam logic [7:0]  ADDR_WORD0        = 8'h0c;
  localparam logic [7:0]  ADDR_INT_STATUS   = 8'h10;
  localparam logic [7:0]  ADDR_INT_CLEAR    = 8'h14;
  localparam logic [7:0]  ADDR_INT_ENABLE   = 8'h18;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and interrupt layout
  localparam logic [3:0]  CTRL_RESET        = 4'h0;
  localparam logic [4:0]  INT_EN_RESET      = 5'h00;
  localparam int unsigned INT_LOAD_DONE     = 0;
  localparam int unsigned INT_FAULT_LSB     = 1;
  localparam logic [15:0] VENDOR_ID_DEFAULT = 16'h1234; // Arbitrary value
  localparam logic [15:0] PRODUCT_ID_DEFAULT = 16'h5678; // Arbitrary value

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {
    ST_STRAP_WAIT = 3'b000,
    ST_SEND       = 3'b001,
    ST_RECV       = 3'b010,
    ST_DONE       = 3'b011,
    ST_SKIP       = 3'b100
  } hsl_state_e;

  typedef struct packed {
    logic [15:0] word0;
    logic [15:0] vendor_identifier;
    logic [15:0] product_identifier;
  } hsl_ident_s;

endpackage : hsl_pkg

//--- hsl_loader_asserts.sv
// Port checker for the serial identifier loader
`timescale 1ns/1ps
module hsl_loader_asserts
  import hsl_pkg::*;
(
  // Watched inputs
  input wire logic                 i_clk,
  input wire logic                 i_rst,
  input wire logic                 i_psel,
  input wire logic                 i_penable,
  input wire logic                 i_ext_memory_enable_n,
  input wire logic [NUM_PORTS-1:0] i_overcurrent_n,
  // Watched outputs
  input wire logic                 o_pready,
  input wire logic                 o_pslverr,
  input wire logic                 o_serial_memory_clock,
  input wire logic                 o_serial_memory_clock_oe,
  input wire logic                 o_serial_memory_data,
  input wire logic                 o_serial_memory_data_oe,
  input wire logic                 o_pulldown_en,
  input wire logic [NUM_PORTS-1:0] o_port_power_on
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  // Count of serial clock falls since reset
  logic       sclk_q_r;
  logic [5:0] fall_cnt_r;
  wire        sclk_fell = sclk_q_r & ~o_serial_memory_clock;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sclk_q_r   <= 1'b0;
      fall_cnt_r <= 6'h00;
    end else begin
      sclk_q_r <= o_serial_memory_clock;
      if (sclk_fell && fall_cnt_r != 6'h3f) fall_cnt_r <= fall_cnt_r + 6'h01;
    end
  end

  pull_on_a: assert property ((!i_rst && !i_ext_memory_enable_n) [*4] |-> o_pulldown_en)
    else $error("pull-down off while strap low");
  pull_off_a: assert property ((!i_rst && i_ext_memory_enable_n) [*4] |-> !o_pulldown_en)
    else $error("pull-down on while strap high");
  no_load_a: assert property (i_ext_memory_enable_n [*4] |-> !o_serial_memory_clock_oe)
    else $error("serial clock driven while strap high");
  one_read_a: assert property (fall_cnt_r < 6'h3a)
    else $error("more serial clocks than one read");
  cmd_edge_a: assert property (o_serial_memory_data_oe && $past(o_serial_memory_data_oe)
    && $changed(o_serial_memory_data) |-> $fell(o_serial_memory_clock))
    else $error("command bit moved off a falling clock");
  data_release_a: assert property (fall_cnt_r >= 6'h08 |-> !o_serial_memory_data_oe)
    else $error("data line still driven after address");
  clk_half_a: assert property ($rose(o_serial_memory_clock) |->
    o_serial_memory_clock [*8] ##1 !o_serial_memory_clock)
    else $error("serial clock high phase not 8 cycles");
  pins_float_a: assert property (fall_cnt_r == 6'h39 |-> ##[0:2]
    (!o_serial_memory_clock_oe && !o_serial_memory_data_oe))
    else $error("pins not floated after third word");
  fault_off_a: assert property ((!i_overcurrent_n[1]) [*6] |-> !o_port_power_on[1])
    else $error("faulted port still powered");
  apb_wait_a: assert property (i_psel && $rose(i_penable) |-> !o_pready ##1 o_pready)
    else $error("ready not in second access cycle");
  one_pulse_a: assert property (o_pready |=> !o_pready && !o_pslverr)
    else $error("ready or error longer than one cycle");
endmodule : hsl_loader_asserts

bind hsl_loader hsl_loader_asserts u_asserts (
  .i_clk, .i_rst, .i_psel, .i_penable, .i_ext_memory_enable_n, .i_overcurrent_n,
  .o_pready, .o_pslverr, .o_serial_memory_clock, .o_serial_memory_clock_oe,
  .o_serial_memory_data, .o_serial_memory_data_oe, .o_pulldown_en, .o_port_power_on
);

//--- hsl_mem_model.sv
// Behavioural serial memory with auto-increment read
`timescale 1ns/1ps
module hsl_mem_model #(
  parameter logic [47:0] CONTENT = 48'h0
) (
  // Pins
  input  wire logic  i_rst,
  input  wire logic  i_cs,
  input  wire logic  i_sclk,
  input  wire logic  i_sdata,
  output logic       o_sdata,
  output logic       o_sdata_oe,
  // Observation
  output logic [7:0] o_cmd,
  output int         o_reads
);
  logic drive_r;
  int   rise_n;
  assign o_sdata_oe = drive_r & i_cs;
  initial o_reads = 0;
  always @(posedge i_sclk or posedge i_rst) begin
    if (i_rst) begin
      rise_n  <= 0;
      o_cmd   <= 8'h00;
      drive_r <= 1'b0;
      o_sdata <= 1'b1;
    end else begin
      rise_n <= rise_n + 1;
      if (rise_n < 8) o_cmd <= {o_cmd[6:0], i_sdata};
      if (rise_n == 7) o_reads <= o_reads + 1;
      if (rise_n == 8) drive_r <= 1'b1;
      if (rise_n == 8) o_sdata <= 1'b0;
      else if (rise_n > 8 && rise_n < 57) o_sdata <= CONTENT[56-rise_n];
    end
  end
endmodule : hsl_mem_model

//--- hsl_loader_bench.sv
// Self-checking bench for the serial identifier loader
`timescale 1ns/1ps
module hsl_loader_bench;
  import hsl_pkg::*;
  localparam logic [15:0] W0 = 16'h4000;
  localparam logic [15:0] VEND_W = 16'ha5c3;
  localparam logic [15:0] PROD_W = 16'h3c5a;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0;
  logic i_ext_memory_enable_n = 1'b0;
  logic i_bus_power_select = 1'b0;
  logic [3:0] i_overcurrent_n = 4'hf;
  logic gang_v = 1'b0;
  logic [31:0] o_prdata, q;
  logic o_pready, o_pslverr, ck, ck_oe, d_o, d_oe, pd_en, m_d, m_oe, o_irq, e;
  logic [3:0] o_port_power_on;
  logic [1:0] o_power_mode;
  logic [7:0] m_cmd;
  int m_reads, fails = 0, n_checks = 0, cyc = 0;
  wire s_clk_w = ck_oe ? ck : 1'b0;
  wire s_dat_w = d_oe ? d_o : m_oe ? m_d : pd_en ? 1'b0 : gang_v;

  hsl_loader dut (
    .i_clk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
    .o_pready, .o_pslverr, .i_ext_memory_enable_n, .i_bus_power_select, .i_overcurrent_n,
    .o_serial_memory_clock(ck), .o_serial_memory_clock_oe(ck_oe),
    .i_serial_memory_data(s_dat_w), .o_serial_memory_data(d_o),
    .o_serial_memory_data_oe(d_oe), .o_pulldown_en(pd_en), .o_port_power_on,
    .o_power_mode, .o_irq
  );
  hsl_mem_model #(.CONTENT({W0, VEND_W, PROD_W})) u_mem (
    .i_rst, .i_cs(ck_oe), .i_sclk(s_clk_w), .i_sdata(s_dat_w), .o_sdata(m_d),
    .o_sdata_oe(m_oe), .o_cmd(m_cmd), .o_reads(m_reads)
  );

  ////////////////////////////////////////////////////////////////////////
  always #2.5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      wrap_up();
    end
  end

  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(posedge i_clk);
  endtask : idle

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rq, output logic re);
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do @(posedge i_clk); while (o_pready !== 1'b1);
    rq = o_prdata;
    re = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] rq;
    logic re;
    apb(1'b0, a, 32'h0, rq, re);
    chk(rq, x);
    chk({31'h0, re}, {31'h0, xe});
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rq;
    logic re;
    apb(1'b1, a, d, rq, re);
    chk({31'h0, re}, 32'h0);
  endtask : wr

  task automatic do_reset(input logic strap);
    i_rst <= 1'b1;
    i_ext_memory_enable_n <= strap;
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
  endtask : do_reset

  ////////////////////////////////////////////////////////////////////////
  initial begin
    // Load from memory, ganged bit set in word zero
    do_reset(1'b0);
    rd(ADDR_CTRL, 32'h0, 1'b0);
    rd(ADDR_INT_ENABLE, 32'h0, 1'b0);
    do apb(1'b0, ADDR_STATUS, 32'h0, q, e); while (q[2:0] !== 3'h3);
    // Mode settles two cycles after the done state, so read again
    apb(1'b0, ADDR_STATUS, 32'h0, q, e);
    chk(q & 32'hef, 32'h63);
    chk({24'h0, m_cmd}, 32'hc0);
    chk(m_reads, 1);
    rd(ADDR_IDENT, {VEND_W, PROD_W}, 1'b0);
    rd(ADDR_WORD0, {16'h0, W0}, 1'b0);
    chk({ck_oe, d_oe, pd_en, o_irq}, 4'h2);
    rd(ADDR_INT_STATUS, 32'h1, 1'b0);
    wr(ADDR_INT_ENABLE, 32'h1);
    idle(3);
    chk(o_irq, 1'b1);
    wr(ADDR_INT_CLEAR, 32'h1);
    idle(3);
    chk(o_irq, 1'b0);
    rd(ADDR_INT_STATUS, 32'h0, 1'b0);
    rd(8'h40, 32'h0, 1'b1);
    wr(ADDR_IDENT, 32'hffffffff);
    rd(ADDR_IDENT, {VEND_W, PROD_W}, 1'b0);
    idle(1500);
    chk(m_reads, 1);
    // Strap high: no load, ganged level from data pin
    i_bus_power_select <= 1'b1;
    do_reset(1'b1);
    idle(20);
    apb(1'b0, ADDR_STATUS, 32'h0, q, e);
    chk(q & 32'hef, 32'h84);
    rd(ADDR_IDENT, {VENDOR_ID_DEFAULT, PRODUCT_ID_DEFAULT}, 1'b0);
    chk({ck_oe, pd_en}, 2'h0);
    chk(m_reads, 1);
    wr(ADDR_CTRL, 32'hf);
    idle(6);
    chk(o_port_power_on, 4'hf);
    i_overcurrent_n <= 4'hd;
    idle(8);
    chk(o_port_power_on, 4'hd);
    apb(1'b0, ADDR_INT_STATUS, 32'h0, q, e);
    chk(q & 32'h1e, 32'h04);
    i_overcurrent_n <= 4'hf;
    wr(ADDR_INT_CLEAR, 32'h1e);
    idle(6);
    chk(o_port_power_on, 4'hf);
    gang_v <= 1'b1;
    idle(6);
    chk(o_power_mode, 2'h3);
    i_overcurrent_n <= 4'h7;
    idle(8);
    chk(o_port_power_on, 4'h0);
    wrap_up();
  end
endmodule : hsl_loader_bench
